/* inc/ppx_pkg.sv */
// constants and carriers for the priority pin crossbar
// assumes one system clock and the chip reset; pins P0.0..P2.6 indexed 0..22
package ppx_pkg;
  localparam int NPIN = 23;
  localparam int NSLOT = 25;
  localparam int NFIXED = 6;
  localparam int PW = 5;
  // signal slots in priority order
  localparam int S_UART_TX = 0;
  localparam int S_UART_RX = 1;
  localparam int S_RSPI_NSS = 5;
  localparam int S_MSPI_SCK = 6;
  localparam int S_MSPI_MISO = 7;
  localparam int S_MSPI_NSS = 9;
  localparam int S_SMB_SDA = 10;
  localparam int S_SMB_SCL = 11;
  localparam int S_CMP0 = 12;
  localparam int S_SYSCLK = 16;
  localparam int S_COUNTER_ARRAY_CHANNELS = 17;
  localparam int N_PCA = 6;
  localparam int S_T0 = 23;
  localparam int S_T1 = 24;
  // fixed pins of the two top peripherals
  localparam logic [PW-1:0] FIX_PIN [NFIXED] =
    '{5'h04, 5'h05, 5'h08, 5'h09, 5'h0a, 5'h0b};
  // fixed analog pins
  localparam int PIN_VREF = 0;
  localparam int PIN_ANALOG_GROUND_REFERENCE = 1;
  localparam int PIN_XTAL_IN = 2;
  localparam int PIN_XTAL_OUT = 3;
  localparam int PIN_IREF = 7;
  // ext irq pin config fields
  localparam int EXT0_LSB = 0;
  localparam int EXT1_LSB = 4;
  // reset values
  localparam logic [NPIN-1:0] DRIVE_RST = 23'h000000;
  localparam logic [NPIN-1:0] OE_N_RST = 23'h7fffff;
  localparam logic [NSLOT-1:0] PIN_IN_IDLE = 25'h1ffffff;
  typedef struct packed {
    logic uart;
    logic rspi;
    logic mspi;
    logic smb;
    logic cmp0;
    logic cmp0_async;
    logic cmp1;
    logic cmp1_async;
    logic sysclk;
    logic [2:0] pca_count;
    logic t0;
    logic t1;
  } ppx_xbar_sel_s;
  typedef struct packed {
    logic iref;
    logic xtal_out;
    logic xtal_in;
    logic analog_ground_reference;
    logic vref;
  } ppx_analog_s;
endpackage

/* rtl/ppx_crossbar.sv */
// priority pin crossbar: assigns enabled peripheral signals to port pins
// assumes pads outside resolve out/oe_n; all inputs synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module ppx_crossbar
  import ppx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic crossbar_global_enable_i,
  input wire ppx_pkg::ppx_xbar_sel_s crossbar_sel_i,
  input wire logic main_spi_four_wire_i,
  input wire logic radio_spi_four_wire_i,
  input wire logic [7:0] port0_crossbar_skip_mask_i,
  input wire logic [7:0] port1_crossbar_skip_mask_i,
  input wire logic [7:0] port2_crossbar_skip_mask_i,
  input wire logic [ppx_pkg::NPIN-1:0] port_output_mode_select_i,
  input wire logic [ppx_pkg::NPIN-1:0] port_drive_strength_select_i,
  input wire logic [ppx_pkg::NPIN-1:0] port_latch_i,
  input wire logic [ppx_pkg::NPIN-1:0] port_digital_mode_i,
  input wire logic [ppx_pkg::NSLOT-1:0] periph_out_i,
  input wire logic [ppx_pkg::NSLOT-1:0] periph_oe_i,
  input wire logic [ppx_pkg::NPIN-1:0] pad_in_i,
  input wire logic [7:0] ext_irq_pin_config_i,
  input wire logic [7:0] port0_match_mask_i,
  input wire logic [7:0] port0_match_value_i,
  input wire logic [7:0] port1_match_mask_i,
  input wire logic [7:0] port1_match_value_i,
  output logic [ppx_pkg::NPIN-1:0] pad_out_o,
  output logic [ppx_pkg::NPIN-1:0] pad_oe_n_o,
  output logic [ppx_pkg::NPIN-1:0] pad_drive_high_o,
  output logic [ppx_pkg::NPIN-1:0] port_read_o,
  output logic [ppx_pkg::NSLOT-1:0] periph_in_o,
  output logic [ppx_pkg::NSLOT-1:0] slot_assigned_o,
  output logic [1:0] ext_irq_o,
  output logic port_match_o,
  output ppx_pkg::ppx_analog_s analog_ready_o
);
  import ppx_pkg::*;

  logic [NPIN-1:0] skip;
  logic [NSLOT-1:0] slot_en;
  logic [PW-1:0] slot_pin_next [NSLOT];
  logic [NSLOT-1:0] slot_ok_next;
  logic [PW-1:0] slot_pin_reg [NSLOT];
  logic [NSLOT-1:0] slot_ok_reg;
  logic [NPIN-1:0] own_ok;
  logic [NPIN-1:0] own_smb;
  logic [NPIN-1:0] own_val;
  logic [NPIN-1:0] own_want;
  logic [NPIN-1:0] pad_out_next;
  logic [NPIN-1:0] pad_oe_n_next;
  logic [NPIN-1:0] pin_in_reg;
  logic [NSLOT-1:0] periph_in_next;
  logic [15:0] match_diff;

  // one skip bit per pin; P2.7 is outside the crossbar
  assign skip = {port2_crossbar_skip_mask_i[6:0], port1_crossbar_skip_mask_i,
                 port0_crossbar_skip_mask_i};

  // per-slot request, in fixed priority order
  always_comb
  begin
    slot_en = '0;
    slot_en[S_UART_TX] = crossbar_sel_i.uart;
    slot_en[S_UART_RX] = crossbar_sel_i.uart;
    slot_en[4:2] = {3{crossbar_sel_i.rspi}};
    slot_en[S_RSPI_NSS] = crossbar_sel_i.rspi & radio_spi_four_wire_i;
    slot_en[8:6] = {3{crossbar_sel_i.mspi}};
    slot_en[S_MSPI_NSS] = crossbar_sel_i.mspi & main_spi_four_wire_i;
    slot_en[S_SMB_SDA] = crossbar_sel_i.smb;
    slot_en[S_SMB_SCL] = crossbar_sel_i.smb;
    slot_en[S_CMP0] = crossbar_sel_i.cmp0;
    slot_en[S_CMP0+1] = crossbar_sel_i.cmp0_async;
    slot_en[S_CMP0+2] = crossbar_sel_i.cmp1;
    slot_en[S_CMP0+3] = crossbar_sel_i.cmp1_async;
    slot_en[S_SYSCLK] = crossbar_sel_i.sysclk;
    for (int c = 0; c < N_PCA; c++)
    begin
      slot_en[S_COUNTER_ARRAY_CHANNELS+c] = (32'(crossbar_sel_i.pca_count) > c);
    end
    slot_en[S_T0] = crossbar_sel_i.t0;
    slot_en[S_T1] = crossbar_sel_i.t1;
  end

  // priority decode: fixed pins first, then lowest free unskipped pin
  always_comb
  begin
    logic [NPIN-1:0] taken;
    logic found;
    taken = '0;
    found = 1'b0;
    slot_ok_next = '0;
    for (int s = 0; s < NSLOT; s++)
    begin
      slot_pin_next[s] = '0;
    end
    for (int s = 0; s < NFIXED; s++)
    begin
      if (slot_en[s])
      begin
        slot_pin_next[s] = FIX_PIN[s];
        slot_ok_next[s] = 1'b1;
        taken[FIX_PIN[s]] = 1'b1;
      end
    end
    for (int s = NFIXED; s < NSLOT; s++)
    begin
      found = 1'b0;
      for (int p = 0; p < NPIN; p++)
      begin
        // skipped or taken pins are passed over
        if (slot_en[s] && !found && !skip[p] && !taken[p])
        begin
          slot_pin_next[s] = PW'(p);
          slot_ok_next[s] = 1'b1;
          taken[p] = 1'b1;
          found = 1'b1;
        end
      end
    end
  end

  // map recomputed every cycle, so any setting change lands one edge later
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      slot_ok_reg <= '0;
      for (int s = 0; s < NSLOT; s++)
      begin
        slot_pin_reg[s] <= '0;
      end
    end
    else
    begin
      slot_ok_reg <= slot_ok_next;
      for (int s = 0; s < NSLOT; s++)
      begin
        slot_pin_reg[s] <= slot_pin_next[s];
      end
    end
  end

  // pin owner lookup from the registered map
  always_comb
  begin
    own_ok = '0;
    own_smb = '0;
    own_val = '0;
    own_want = '0;
    for (int s = 0; s < NSLOT; s++)
    begin
      if (slot_ok_reg[s])
      begin
        own_ok[slot_pin_reg[s]] = 1'b1;
        own_val[slot_pin_reg[s]] = periph_out_i[s];
        own_want[slot_pin_reg[s]] = periph_oe_i[s];
        own_smb[slot_pin_reg[s]] = (s == S_SMB_SDA) || (s == S_SMB_SCL);
      end
    end
  end

  // per-pin driver: unowned pins act as GPIO from the latch
  for (genvar p = 0; p < NPIN; p++)
  begin : g_pin
    logic val;
    logic want;
    logic od;
    assign val = own_ok[p] ? own_val[p] : port_latch_i[p];
    assign want = own_ok[p] ? own_want[p] : 1'b1;
    assign od = ~port_output_mode_select_i[p] | own_smb[p];
    assign pad_out_next[p] = val;
    // open-drain only pulls low; all drivers off without the global enable
    assign pad_oe_n_next[p] = ~(crossbar_global_enable_i & want
                                & (~od | ~val));
  end

  // pad drive registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pad_out_o <= '0;
      pad_oe_n_o <= OE_N_RST;
    end
    else
    begin
      pad_out_o <= pad_out_next;
      pad_oe_n_o <= pad_oe_n_next;
    end
  end

  // drive strength follows software; low strength out of reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pad_drive_high_o <= DRIVE_RST;
    end
    else
    begin
      pad_drive_high_o <= port_drive_strength_select_i;
    end
  end

  // digital receiver gated off on analog pins, so they read zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_in_reg <= '0;
    end
    else
    begin
      pin_in_reg <= pad_in_i & port_digital_mode_i;
    end
  end
  assign port_read_o = pin_in_reg;

  // inputs routed back to peripherals; unassigned inputs idle high
  always_comb
  begin
    periph_in_next = PIN_IN_IDLE;
    for (int s = 0; s < NSLOT; s++)
    begin
      if (slot_ok_reg[s])
      begin
        periph_in_next[s] = pin_in_reg[slot_pin_reg[s]];
      end
    end
  end

  // event capture works on digital pins P0.0..P1.7 (port match) and P0.0..P0.7 (ext irq), skipped or claimed
  assign match_diff = (pin_in_reg[15:0] ^ {port1_match_value_i, port0_match_value_i})
                      & {port1_match_mask_i, port0_match_mask_i};

  // peripheral inputs, event lines and analog readiness
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      periph_in_o <= PIN_IN_IDLE;
      slot_assigned_o <= '0;
      ext_irq_o <= '0;
      port_match_o <= 1'b0;
      analog_ready_o <= '0;
    end
    else
    begin
      periph_in_o <= periph_in_next;
      slot_assigned_o <= slot_ok_reg;
      ext_irq_o[0] <= pin_in_reg[ext_irq_pin_config_i[EXT0_LSB +: 3]];
      ext_irq_o[1] <= pin_in_reg[ext_irq_pin_config_i[EXT1_LSB +: 3]];
      port_match_o <= |match_diff;
      // an analog function is usable once its pin is analog and skipped
      analog_ready_o.vref <= skip[PIN_VREF] & ~port_digital_mode_i[PIN_VREF];
      analog_ready_o.analog_ground_reference <= skip[PIN_ANALOG_GROUND_REFERENCE] & ~port_digital_mode_i[PIN_ANALOG_GROUND_REFERENCE];
      analog_ready_o.xtal_in <= skip[PIN_XTAL_IN] & ~port_digital_mode_i[PIN_XTAL_IN];
      analog_ready_o.xtal_out <= skip[PIN_XTAL_OUT] & ~port_digital_mode_i[PIN_XTAL_OUT];
      analog_ready_o.iref <= skip[PIN_IREF] & ~port_digital_mode_i[PIN_IREF];
    end
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [NPIN-1:0] claimed_dyn;
  always_comb
  begin
    claimed_dyn = '0;
    for (int s = NFIXED; s < NSLOT; s++)
    begin
      if (slot_ok_reg[s])
      begin
        claimed_dyn[slot_pin_reg[s]] = 1'b1;
      end
    end
  end

  sequence seq_off_two;
    !crossbar_global_enable_i ##1 1'b1;
  endsequence

  chk_drivers_off: assert property (seq_off_two |-> &pad_oe_n_o)
    else $error("pad driven while crossbar disabled");
  chk_uart_fixed: assert property (crossbar_sel_i.uart |=> slot_ok_reg[S_UART_TX]
    && slot_pin_reg[S_UART_TX] == 5'h04 && slot_pin_reg[S_UART_RX] == 5'h05)
    else $error("serial port not on fixed pins");
  chk_radio_nss: assert property (crossbar_sel_i.rspi && radio_spi_four_wire_i |=>
    slot_ok_reg[S_RSPI_NSS] && slot_pin_reg[S_RSPI_NSS] == 5'h0b)
    else $error("radio select pin wrong");
  chk_skip_never: assert property (##1 (claimed_dyn & $past(skip)) == '0)
    else $error("skipped pin claimed");
  chk_main_nss: assert property (crossbar_sel_i.mspi && !main_spi_four_wire_i
    |=> !slot_ok_reg[S_MSPI_NSS])
    else $error("select pin claimed in three-wire mode");
  chk_smb_open: assert property (slot_ok_reg[S_SMB_SDA] |=>
    (pad_oe_n_o[$past(slot_pin_reg[S_SMB_SDA])] || !pad_out_o[$past(slot_pin_reg[S_SMB_SDA])]))
    else $error("smbus pin driven high");
  chk_analog_zero: assert property (##1
    (pin_in_reg & ~$past(port_digital_mode_i)) == '0)
    else $error("analog pin reads one");
  chk_order_up: assert property (slot_ok_reg[S_MSPI_SCK] && slot_ok_reg[S_MSPI_MISO]
    |-> slot_pin_reg[S_MSPI_MISO] > slot_pin_reg[S_MSPI_SCK])
    else $error("priority order broken");
  chk_drive_follow: assert property (##1
    pad_drive_high_o == $past(port_drive_strength_select_i))
    else $error("drive strength not applied");
  chk_ext_irq: assert property (##1 ext_irq_o[0]
    == $past(pin_in_reg[ext_irq_pin_config_i[2:0]]))
    else $error("external irq pin select wrong");
endmodule
`default_nettype wire

/* verification/ppx_pad_partner.sv */
// pad partner: resolves each pin from device drive, outside pull-downs and pull-ups
// assumes pad_oe_n low means the device drives its pin
`timescale 1ns/1ns
`default_nettype none
module ppx_pad_partner
  import ppx_pkg::*;
(
  input wire logic [ppx_pkg::NPIN-1:0] pad_out_i,
  input wire logic [ppx_pkg::NPIN-1:0] pad_oe_n_i,
  input wire logic [ppx_pkg::NPIN-1:0] ext_low_i,
  output logic [ppx_pkg::NPIN-1:0] pad_in_o
);
  // weak pull-up wins unless the device or the outside world pulls low;
  // contention (device high against outside low) is never commanded
  assign pad_in_o = ~((~pad_oe_n_i & ~pad_out_i) | ext_low_i);
endmodule
`default_nettype wire

/* verification/ppx_crossbar_tb.sv */
// testbench for the priority pin crossbar: sets levels, checks pads and slot map
// assumes the pad partner resolves every pin with a weak pull-up
`timescale 1ns/1ns
`default_nettype none
module ppx_crossbar_tb;
  import ppx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic xen = 1'b0;
  ppx_xbar_sel_s sel = '0;
  logic mspi4 = 1'b0;
  logic rspi4 = 1'b0;
  logic [7:0] skip0 = 8'h00, skip1 = 8'h00, skip2 = 8'h00, ext_cfg = 8'h00;
  logic [7:0] m0mask = 8'h00, m0val = 8'h00, m1mask = 8'h80, m1val = 8'h80;
  logic [NPIN-1:0] mode = '0, drv = '0, latch = '1, dig = '1, ext_low = '0;
  logic [NPIN-1:0] pad_in, pad_out, pad_oe_n, drive_high, port_read;
  logic [NSLOT-1:0] pout = '1, poe = '0, pin_in, assigned;
  logic [1:0] ext_irq;
  logic match;
  ppx_analog_s analog;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  ppx_crossbar dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .crossbar_global_enable_i(xen),
    .crossbar_sel_i(sel),
    .main_spi_four_wire_i(mspi4),
    .radio_spi_four_wire_i(rspi4),
    .port0_crossbar_skip_mask_i(skip0),
    .port1_crossbar_skip_mask_i(skip1),
    .port2_crossbar_skip_mask_i(skip2),
    .port_output_mode_select_i(mode),
    .port_drive_strength_select_i(drv),
    .port_latch_i(latch),
    .port_digital_mode_i(dig),
    .periph_out_i(pout),
    .periph_oe_i(poe),
    .pad_in_i(pad_in),
    .ext_irq_pin_config_i(ext_cfg),
    .port0_match_mask_i(m0mask),
    .port0_match_value_i(m0val),
    .port1_match_mask_i(m1mask),
    .port1_match_value_i(m1val),
    .pad_out_o(pad_out),
    .pad_oe_n_o(pad_oe_n),
    .pad_drive_high_o(drive_high),
    .port_read_o(port_read),
    .periph_in_o(pin_in),
    .slot_assigned_o(assigned),
    .ext_irq_o(ext_irq),
    .port_match_o(match),
    .analog_ready_o(analog)
  );
  ppx_pad_partner partner (
    .pad_out_i(pad_out),
    .pad_oe_n_i(pad_oe_n),
    .ext_low_i(ext_low),
    .pad_in_o(pad_in)
  );
  // 125 MHz system clock
  always #4 clk_i = ~clk_i;
  // hang guard: the whole sequence needs under two hundred cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // map, pads, pin read and peripheral input need four edges; six gives margin
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask
  // one slot drives 0, everything else released: only its pin may pull low
  task automatic probe(input int slot, input int pin);
    logic [NPIN-1:0] exp;
    exp = (pin < 0) ? '1 : ~(23'h1 << pin);
    poe <= 25'h1 << slot;
    pout <= ~(25'h1 << slot);
    settle();
    compare(pad_oe_n, exp);
    compare(pad_out, exp);
    compare(assigned[slot], pin >= 0);
    compare(pin_in[slot], pin < 0);
  endtask
  initial
  begin
    repeat (15) @(posedge clk_i);
    compare(drive_high, DRIVE_RST);
    compare(pad_oe_n, OE_N_RST);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    drv <= 23'h5a5a5a;
    mode <= '1;
    latch <= '0;
    settle();
    compare(drive_high, 23'h5a5a5a);
    compare(pad_oe_n, OE_N_RST);
    xen <= 1'b1;
    settle();
    compare(pad_oe_n, 23'h0);
    // open-drain with latch high releases every unowned pin
    mode <= '0;
    latch <= '1;
    sel.smb <= 1'b1;
    probe(S_SMB_SDA, 0);
    probe(S_SMB_SCL, 1);
    sel <= '{uart: 1'b1, smb: 1'b1, cmp0: 1'b1, default: '0};
    skip0 <= 8'h0c;
    probe(S_UART_TX, 4);
    probe(S_UART_RX, 5);
    probe(S_CMP0, 6);
    skip0 <= 8'h30;
    probe(S_UART_TX, 4);
    probe(S_CMP0, 2);
    // push-pull selected, but the data pin must stay open-drain
    mode <= '1;
    poe <= 25'h1 << S_SMB_SDA;
    pout <= '1;
    settle();
    compare(pad_oe_n[0], 1'b1);
    compare(pad_oe_n[7], 1'b0);
    // analog pins reserved: skip, open-drain, latch high
    mode <= '0;
    skip0 <= 8'h8f;
    dig <= 23'h7fff70;
    poe <= '0;
    settle();
    compare(analog, 5'h1f);
    compare(port_read, 23'h7fff70);
    probe(S_SMB_SDA, 6);
    probe(S_SMB_SCL, 8);
    probe(S_CMP0, 9);
    sel <= '{rspi: 1'b1, mspi: 1'b1, smb: 1'b1, default: '0};
    skip0 <= 8'h00;
    dig <= '1;
    probe(S_MSPI_SCK, 0);
    probe(S_MSPI_NSS, -1);
    probe(S_SMB_SDA, 3);
    probe(S_RSPI_NSS, -1);
    mspi4 <= 1'b1;
    rspi4 <= 1'b1;
    probe(S_MSPI_NSS, 3);
    probe(S_SMB_SDA, 4);
    probe(S_RSPI_NSS, 11);
    // pin levels reach the event capture logic
    sel <= '0;
    poe <= '0;
    ext_cfg <= 8'h62;
    ext_low <= 23'h4;
    m0mask <= 8'h04;
    m0val <= 8'h04;
    settle();
    compare(ext_irq, 2'b10);
    compare(match, 1'b1);
    ext_low <= '0;
    settle();
    compare(ext_irq, 2'b11);
    compare(match, 1'b0);
    sel.smb <= 1'b1;
    ext_cfg <= 8'h10;
    ext_low <= 23'h1;
    settle();
    compare(ext_irq, 2'b10);
    compare(pin_in[S_SMB_SDA], 1'b0);
    ext_low <= '0;
    skip0 <= 8'hff;
    skip1 <= 8'hff;
    skip2 <= 8'hff;
    probe(S_SMB_SDA, -1);
    end_of_test();
  end
endmodule
`default_nettype wire
